// >>> pcm_pkg.sv
// shared constants and types for the clock manager
`default_nettype none
package pcm_pkg;
  // ==========================================
  // loop counts and factor limits
  localparam int unsigned NUM_LOOPS      = 4;
  localparam int unsigned NUM_SMALL      = 2;
  localparam int unsigned NUM_SERIAL     = 2;
  localparam int unsigned MK_W           = 8;
  localparam int unsigned NV_W           = 5;
  localparam logic [7:0]  MK_MIN         = 8'h02;
  localparam logic [7:0]  MK_MAX         = 8'hA0;
  localparam logic [4:0]  NV_MIN         = 5'h01;
  localparam logic [4:0]  NV_MAX         = 5'h10;
  localparam int unsigned PH_W           = 2;
  localparam int unsigned DLY_W          = 9;
  localparam int unsigned PER_W          = 16;
  // ==========================================
  // legacy multiplier encodings
  localparam logic [1:0]  MUL_X1         = 2'h0;
  localparam logic [1:0]  MUL_X2         = 2'h1;
  localparam logic [1:0]  MUL_X4         = 2'h2;
  // ==========================================
  // lock timing
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned LOCK_TIME_US   = 10;
  localparam int unsigned LOCK_CYC       = LOCK_TIME_US * CLK_MHZ;
  localparam int unsigned LOCK_W         = 10;
  localparam logic [9:0]  LOCK_CYC_V     = 10'(LOCK_CYC);
  localparam logic [9:0]  LOCK_ZERO      = 10'h000;
  // loss of reference: no edge for this many cycles
  localparam logic [7:0]  REF_LOSS_CYC   = 8'h40;
  localparam logic [7:0]  REF_ZERO       = 8'h00;

  typedef enum logic [1:0] {
    PCM_ST_IDLE,
    PCM_ST_ACQ,
    PCM_ST_LOCK
  } pcm_state_e;
endpackage
`default_nettype wire

// >>> pcm_cfg_if.sv
// configuration carrier between top and one loop
`default_nettype none
interface pcm_cfg_if;
  logic [7:0] m_fac;
  logic [4:0] n_fac;
  logic [7:0] k_fac;
  logic [4:0] v_fac;
  logic [1:0] phase;
  logic [8:0] delay;
  logic       enable;
  logic       ref_edge;
  logic       cfg_done;
  logic       valid;
  logic       locked;
  modport ctrl (output m_fac, n_fac, k_fac, v_fac, phase, delay, enable,
                ref_edge, cfg_done, input valid, locked);
  modport loop (input m_fac, n_fac, k_fac, v_fac, phase, delay, enable,
                ref_edge, cfg_done, output valid, locked);
endinterface
`default_nettype wire

// >>> pcm_loop.sv
// one enhanced loop: factor check, lock acquisition, reference watchdog
`default_nettype none
module pcm_loop
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // configuration
  pcm_cfg_if.loop   cfg
);
  typedef struct packed {
    pcm_state_e  st;
    logic [9:0]  cnt;
    logic [7:0]  loss;
    logic [28:0] sig;
    logic        lock;
  } pcm_loop_s;

  pcm_loop_s q, d;
  logic      ok;
  logic [28:0] sig_now;

  // ==========================================
  // factor ranges and change detect
  always_comb begin
    ok = (cfg.m_fac >= MK_MIN) && (cfg.m_fac <= MK_MAX) &&
         (cfg.k_fac >= MK_MIN) && (cfg.k_fac <= MK_MAX) &&
         (cfg.n_fac >= NV_MIN) && (cfg.n_fac <= NV_MAX) &&
         (cfg.v_fac >= NV_MIN) && (cfg.v_fac <= NV_MAX);
    sig_now = {cfg.m_fac, cfg.n_fac, cfg.k_fac, cfg.v_fac, cfg.phase,
               cfg.enable};
  end

  // ==========================================
  // lock state machine
  always_comb begin
    d     = q;
    d.sig = sig_now;
    if (cfg.ref_edge) begin
      d.loss = REF_ZERO;
    end else if (q.loss != REF_LOSS_CYC) begin
      d.loss = q.loss + 8'h01;
    end
    case (q.st)
      PCM_ST_IDLE: begin
        d.cnt  = LOCK_ZERO;
        d.lock = 1'b0;
        // reference ignored until configuration is done
        if (cfg.cfg_done && cfg.enable && ok) begin
          d.st = PCM_ST_ACQ;
        end
      end
      PCM_ST_ACQ: begin
        d.cnt = q.cnt + 10'h001;
        if (q.cnt == LOCK_CYC_V - 10'h001) begin
          d.st   = PCM_ST_LOCK;
          d.lock = 1'b1;
        end
      end
      PCM_ST_LOCK: d.lock = 1'b1;
      default:     d.st   = PCM_ST_IDLE;
    endcase
    // reprogram, loss or deconfigure drops lock at once
    if (q.st != PCM_ST_IDLE && (sig_now != q.sig || !ok || !cfg.enable ||
        !cfg.cfg_done || q.loss == REF_LOSS_CYC)) begin
      d.st   = PCM_ST_IDLE;
      d.lock = 1'b0;
      d.cnt  = LOCK_ZERO;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cfg.valid  = ok;
  assign cfg.locked = q.lock;
endmodule
`default_nettype wire

// >>> pcm_phase.sv
// phase step and signed delay adjust for one loop
`default_nettype none
module pcm_phase
  import pcm_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // settings
  input  wire logic [1:0]        phase_sel,
  input  wire logic signed [8:0] delay_req,
  input  wire logic [8:0]        period,
  // result: total offset in fine steps, quarter steps plus a delay clamped to one period
  output logic signed [10:0]     offset
);
  typedef struct packed {
    logic signed [10:0] off;
  } pcm_ph_s;
  pcm_ph_s q, d;
  logic signed [10:0] quarter, dly, per;

  // ==========================================
  // quarter steps plus clamped delay
  always_comb begin
    per     = $signed({2'b00, period});
    quarter = $signed({2'b00, period >> 2}) * $signed({9'h000, phase_sel});
    dly     = 11'(delay_req);
    if (dly > per) dly = per;
    if (dly < -per) dly = -per;
    d.off   = quarter + dly;
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign offset = q.off;
endmodule
`default_nettype wire

// >>> pcm_top.sv
// clock manager top: legacy pairs, enhanced loops, lock pins, routing
// ==========================================
`default_nettype none
module pcm_top
  import pcm_pkg::*;
#(
  parameter int unsigned LOOPS_PRESENT = 4
)(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // configuration state
  input  wire logic              cfg_done,
  input  wire logic              legacy_mode,
  // reference edges seen on the dedicated clock pins
  input  wire logic              first_dedicated_clock_in,
  input  wire logic              second_dedicated_clock_in,
  input  wire logic              both_from_second,
  // legacy multiplier pair
  input  wire logic [1:0]        out1_mul,
  input  wire logic [1:0]        out2_mul,
  // enhanced loop factors, one slice per loop
  input  wire logic [4*8-1:0]    m_fac,
  input  wire logic [4*5-1:0]    n_fac,
  input  wire logic [4*8-1:0]    k_fac,
  input  wire logic [4*5-1:0]    v_fac,
  input  wire logic [4*2-1:0]    phase_sel,
  input  wire logic [4*9-1:0]    delay_req,
  input  wire logic [4*9-1:0]    out_period,
  input  wire logic [3:0]        loop_enable,
  input  wire logic [3:0]        serial_mode,
  // lock pin use and routing
  input  wire logic [3:0]        lock_pin_en,
  input  wire logic [3:0]        gpio_out,
  input  wire logic [3:0]        gpio_oe,
  input  wire logic [3:0]        clk_out_en,
  input  wire logic [3:0]        ext_fb_en,
  input  wire logic [3:0]        fb_pin_in,
  // status
  output logic                   legacy_pair_ok,
  output logic                   legacy_locked,
  output logic                   first_in_blocked,
  output logic [3:0]             loop_locked,
  output logic [3:0]             factor_ok,
  output logic [3:0]             fb_edge_seen,
  output logic [4*11-1:0]        phase_offset,
  // lock pins and clock out pins
  output logic [3:0]             lock_pin_out,
  output logic [3:0]             lock_pin_oe,
  output logic [3:0]             clk_pin_oe
);
  import pcm_pkg::*;

  typedef struct packed {
    logic       r1, r2, fr1, fr2;
    logic       pair_ok;
    pcm_state_e lst;
    logic [9:0] lcnt;
    logic       llock;
    logic       blocked;
    logic [3:0] locked, fok, fbe, fbp;
    logic [3:0] pout, poe, coe;
  } pcm_top_s;

  pcm_top_s q, d;
  logic [3:0]   lk, vl;
  logic [43:0]  offs;
  logic         ref_sel, ref_edge, pair_ok;
  logic [3:0]   present;

  // ==========================================
  // reference select and legacy pair check
  always_comb begin
    // with both circuits on the second input, the first is never looked at
    ref_sel  = both_from_second ? q.r2 : q.r1;
    ref_edge = both_from_second ? (q.r2 & ~q.fr2) : (q.r1 & ~q.fr1);
    case (out2_mul)
      MUL_X1:  pair_ok = (out1_mul == MUL_X1);
      MUL_X2:  pair_ok = (out1_mul == MUL_X1) || (out1_mul == MUL_X2);
      MUL_X4:  pair_ok = (out1_mul == MUL_X1) || (out1_mul == MUL_X2) ||
                         (out1_mul == MUL_X4);
      default: pair_ok = 1'b0;
    endcase
    for (int i = 0; i < 4; i++) begin
      present[i] = (i < LOOPS_PRESENT);
    end
  end

  // ==========================================
  // enhanced loops, one per slot
  generate
    for (genvar g = 0; g < 4; g++) begin : g_loop
      pcm_cfg_if ci();
      assign ci.m_fac    = m_fac[g*8 +: 8];
      assign ci.n_fac    = n_fac[g*5 +: 5];
      // serial slots reuse k for the bit-rate multiply
      assign ci.k_fac    = k_fac[g*8 +: 8];
      assign ci.v_fac    = v_fac[g*5 +: 5];
      assign ci.phase    = phase_sel[g*2 +: 2];
      assign ci.delay    = delay_req[g*9 +: 9];
      assign ci.enable   = loop_enable[g] & present[g] & ~legacy_mode &
                           (g < NUM_SERIAL || !serial_mode[g]);
      assign ci.ref_edge = ref_edge;
      assign ci.cfg_done = cfg_done;
      pcm_loop u_loop (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .cfg     (ci.loop)
      );
      assign lk[g] = ci.locked;
      assign vl[g] = ci.valid;
      pcm_phase u_phase (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .phase_sel (phase_sel[g*2 +: 2]),
        .delay_req (delay_req[g*9 +: 9]),
        .period    (out_period[g*9 +: 9]),
        .offset    (offs[g*11 +: 11])
      );
    end
  endgenerate

  // ==========================================
  // legacy lock runs during configuration so it is ready at its end
  always_comb begin
    d         = q;
    d.r1      = first_dedicated_clock_in;
    d.r2      = second_dedicated_clock_in;
    d.fr1     = q.r1;
    d.fr2     = q.r2;
    d.pair_ok = pair_ok;
    d.blocked = both_from_second;
    case (q.lst)
      PCM_ST_IDLE: begin
        d.lcnt  = LOCK_ZERO;
        d.llock = 1'b0;
        if (legacy_mode && pair_ok && ref_edge) d.lst = PCM_ST_ACQ;
      end
      PCM_ST_ACQ: begin
        d.lcnt = q.lcnt + 10'h001;
        if (q.lcnt == LOCK_CYC_V - 10'h001) begin
          d.lst   = PCM_ST_LOCK;
          d.llock = 1'b1;
        end
      end
      PCM_ST_LOCK: d.llock = 1'b1;
      default:     d.lst   = PCM_ST_IDLE;
    endcase
    if (!legacy_mode || !pair_ok) begin
      d.lst   = PCM_ST_IDLE;
      d.llock = 1'b0;
    end
    d.locked = lk;
    d.fok    = vl;
    // feedback via pin is watched only when ext_fb_en selects it, whatever clk_out_en says
    d.fbp    = fb_pin_in;
    d.fbe    = q.fbe | (ext_fb_en & fb_pin_in & ~q.fbp);
    for (int i = 0; i < 4; i++) begin
      // unused lock pin is handed back as ordinary I/O
      d.pout[i] = lock_pin_en[i] ? lk[i] : gpio_out[i];
      d.poe[i]  = lock_pin_en[i] ? 1'b1 : gpio_oe[i];
      d.coe[i]  = clk_out_en[i] & present[i];
      if (!ext_fb_en[i]) d.fbe[i] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================
  // outputs straight from state
  assign legacy_pair_ok   = q.pair_ok;
  assign legacy_locked    = q.llock;
  assign first_in_blocked = q.blocked;
  assign loop_locked      = q.locked;
  assign factor_ok        = q.fok;
  assign fb_edge_seen     = q.fbe;
  assign phase_offset     = offs;
  assign lock_pin_out     = q.pout;
  assign lock_pin_oe      = q.poe;
  assign clk_pin_oe       = q.coe;
  logic unused_ok;
  assign unused_ok = ref_sel;
endmodule
`default_nettype wire

// >>> pcm_top_properties.sv
// checker of the clock manager top port behaviour
`default_nettype none
module pcm_top_chk
  import pcm_pkg::*;
(
  // clock, reset and settings
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        cfg_done,
  input wire logic        both_from_second,
  input wire logic [1:0]  out1_mul,
  input wire logic [1:0]  out2_mul,
  input wire logic [31:0] m_fac,
  input wire logic [19:0] n_fac,
  input wire logic [35:0] out_period,
  input wire logic [7:0]  phase_sel,
  input wire logic [3:0]  lock_pin_en,
  input wire logic [3:0]  gpio_out,
  input wire logic [3:0]  gpio_oe,
  // status and pins
  input wire logic        legacy_pair_ok,
  input wire logic        legacy_locked,
  input wire logic        first_in_blocked,
  input wire logic [3:0]  loop_locked,
  input wire logic [3:0]  factor_ok,
  input wire logic [43:0] phase_offset,
  input wire logic [3:0]  lock_pin_out,
  input wire logic [3:0]  lock_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0]         age_q;
  logic [9:0]         cfg_q;
  logic               pair_c;
  logic               fac_bad;
  logic signed [10:0] off0;
  logic signed [10:0] per0;
  logic signed [10:0] qtr0;
  // =====
  // saturating ages: since reset, and since configuration finished
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_q <= 10'h000;
      cfg_q <= 10'h000;
    end else begin
      age_q <= age_q + {9'h000, age_q != 10'h3FF};
      cfg_q <= cfg_done ? cfg_q + {9'h000, cfg_q != 10'h3FF} : 10'h000;
    end
  end
  // accepted legacy pairs, loop 0 factor range, loop 0 offset bound
  assign pair_c = (out2_mul == MUL_X1 && out1_mul == MUL_X1) ||
                  (out2_mul == MUL_X2 && out1_mul inside {MUL_X1, MUL_X2}) ||
                  (out2_mul == MUL_X4 && out1_mul inside {MUL_X1, MUL_X2, MUL_X4});
  assign fac_bad = m_fac[7:0] < MK_MIN || m_fac[7:0] > MK_MAX ||
                   n_fac[4:0] < NV_MIN || n_fac[4:0] > NV_MAX;
  assign off0 = phase_offset[10:0];
  assign per0 = {2'h0, out_period[8:0]};
  // quarter-step share of the offset; only the delay part is bounded by a period
  assign qtr0 = 11'(out_period[8:2]) * 11'(phase_sel[1:0]);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // =====
  // properties; age_q skips edges where outputs still show reset
  pair_check_a: assert property (age_q > 2 && !$past(pair_c) |-> !legacy_pair_ok)
    else $error("bad legacy pair accepted");
  first_block_a: assert property (age_q > 2 && !$past(both_from_second) |-> !first_in_blocked)
    else $error("first input blocked without cause");
  cfg_low_a: assert property (!cfg_done [*3] |-> loop_locked == 4'h0)
    else $error("lock while configuring");
  lock_time_a: assert property ($rose(loop_locked[0]) |-> cfg_q >= LOCK_CYC)
    else $error("loop locked too early");
  legacy_time_a: assert property ($rose(legacy_locked) |-> age_q >= LOCK_CYC)
    else $error("legacy locked too early");
  gpio_pass_a: assert property (age_q > 2 && !$past(lock_pin_en[1]) |->
    lock_pin_out[1] == $past(gpio_out[1]) && lock_pin_oe[1] == $past(gpio_oe[1]))
    else $error("released pin not general I/O");
  pin_follow_a: assert property (age_q > 2 && lock_pin_en[0] && $past(lock_pin_en[0]) &&
    $stable(loop_locked[0]) |-> lock_pin_out[0] == loop_locked[0] && lock_pin_oe[0])
    else $error("lock pin not following lock");
  factor_range_a: assert property (age_q > 2 && $past(fac_bad) |-> !factor_ok[0])
    else $error("bad factor accepted");
  offset_clamp_a: assert property (age_q > 3 && $stable(out_period[8:0]) &&
    $stable(phase_sel[1:0]) &&
    $past(out_period[8:0], 2) == out_period[8:0] && $past(out_period[8:0], 3) == out_period[8:0]
    |-> off0 - qtr0 <= per0 && off0 - qtr0 >= -per0)
    else $error("offset beyond one period");
endmodule
bind pcm_top pcm_top_chk i_chk (
  .ref_clk, .sys_rst, .cfg_done, .both_from_second, .out1_mul, .out2_mul, .m_fac, .n_fac,
  .out_period, .phase_sel, .lock_pin_en, .gpio_out, .gpio_oe, .legacy_pair_ok, .legacy_locked,
  .first_in_blocked, .loop_locked, .factor_ok, .phase_offset, .lock_pin_out, .lock_pin_oe
);
`default_nettype wire

// >>> pcm_ref_src.sv
// board side model: reference source on the dedicated clock pins and feedback
`default_nettype none
module pcm_ref_src (
  // clock and control
  input  wire logic  ref_clk,
  input  wire logic  run,
  input  wire logic  use_first,
  // pins toward the device
  output logic       first_dedicated_clock_in,
  output logic       second_dedicated_clock_in,
  output logic [3:0] fb_pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q = 2'h0;
  logic       lvl_q = 1'b0;
  // toggle every four cycles; parked low when stopped, as a quiet source is
  always @(negedge ref_clk) begin
    div_q <= run ? div_q + 2'h1 : 2'h0;
    lvl_q <= run ? lvl_q ^ (div_q == 2'h3) : 1'b0;
  end
  assign second_dedicated_clock_in = lvl_q;
  assign first_dedicated_clock_in = use_first & lvl_q;
  assign fb_pin_in = {4{lvl_q}};
endmodule
`default_nettype wire

// >>> tb_pcm_top.sv
// self-checking bench for the clock manager top
`default_nettype none
module tb_pcm_top;
  import pcm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // =====
  // device inputs, all set at time zero
  logic        ref_clk = 1'b0, sys_rst = 1'b1, cfg_done = 1'b0, legacy_mode = 1'b1;
  logic        both_from_second = 1'b0, run = 1'b0;
  logic [1:0]  out1_mul = 2'h0, out2_mul = 2'h0;
  logic [31:0] m_fac = {4{8'h08}}, k_fac = {4{8'h02}};
  logic [19:0] n_fac = {4{5'h01}}, v_fac = {4{5'h01}};
  logic [7:0]  phase_sel = 8'h00;
  logic [35:0] delay_req = 36'h0, out_period = {4{9'h064}};
  logic [3:0]  loop_enable = 4'hF, serial_mode = 4'h0, lock_pin_en = 4'h5, gpio_out = 4'h0;
  logic [3:0]  gpio_oe = 4'h8, clk_out_en = 4'h3, ext_fb_en = 4'hF, fb_pin_in;
  logic        first_dedicated_clock_in, second_dedicated_clock_in;
  // device outputs
  logic        legacy_pair_ok, legacy_locked, first_in_blocked;
  logic [3:0]  loop_locked, factor_ok, fb_edge_seen, lock_pin_out, lock_pin_oe, clk_pin_oe;
  logic [43:0] phase_offset;
  int          n_errors = 0, n_checks = 0, n;
  pcm_top #(.LOOPS_PRESENT(4)) i_dut (
    .ref_clk, .sys_rst, .cfg_done, .legacy_mode, .first_dedicated_clock_in,
    .second_dedicated_clock_in, .both_from_second, .out1_mul, .out2_mul, .m_fac, .n_fac,
    .k_fac, .v_fac, .phase_sel, .delay_req, .out_period, .loop_enable, .serial_mode,
    .lock_pin_en, .gpio_out, .gpio_oe, .clk_out_en, .ext_fb_en, .fb_pin_in, .legacy_pair_ok,
    .legacy_locked, .first_in_blocked, .loop_locked, .factor_ok, .fb_edge_seen,
    .phase_offset, .lock_pin_out, .lock_pin_oe, .clk_pin_oe
  );
  pcm_ref_src i_src (
    .ref_clk, .run, .use_first(!both_from_second), .first_dedicated_clock_in,
    .second_dedicated_clock_in, .fb_pin_in
  );
  // 40 MHz clock
  initial forever #12.5 ref_clk = ~ref_clk;
  // =====
  // shared helpers
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [43:0] got, input logic [43:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // =====
  // scenarios; legacy table includes the unused code 3
  task automatic t_pairs;
    for (int a = 0; a < 16; a++) begin
      {out1_mul, out2_mul} = 4'(a);
      cyc(2);
      chk(legacy_pair_ok, (out2_mul == MUL_X1 && out1_mul == MUL_X1) ||
          (out2_mul == MUL_X2 && out1_mul inside {MUL_X1, MUL_X2}) ||
          (out2_mul == MUL_X4 && out1_mul inside {MUL_X1, MUL_X2, MUL_X4}));
    end
  endtask
  // legacy lock completes with configuration still running
  task automatic t_legacy;
    {out1_mul, out2_mul} = 4'h0;
    run = 1'b1;
    both_from_second = 1'b1;
    for (n = 0; n < 600 && legacy_locked !== 1'b1; n++) cyc(1);
    chk(n >= LOCK_CYC && n <= LOCK_CYC + 20, 1'b1);
    chk(first_in_blocked, 1'b1);
    chk(loop_locked, 4'h0);
    both_from_second = 1'b0;
  endtask
  // enhanced loops acquire only once configuration is done
  task automatic t_lock;
    legacy_mode = 1'b0;
    cfg_done = 1'b1;
    for (n = 0; n < 600 && loop_locked !== 4'hF; n++) cyc(1);
    chk(n >= LOCK_CYC && n <= LOCK_CYC + 12, 1'b1);
    cyc(2);
    chk({factor_ok, lock_pin_out, lock_pin_oe}, 12'hF5D);
    chk({clk_pin_oe, fb_edge_seen}, 8'h3F);
  endtask
  // loop 0 refused, loop 1 reprogrammed at the range limits
  task automatic t_reprog;
    m_fac[7:0] = 8'hA1;
    m_fac[15:8] = 8'hA0;
    k_fac[15:8] = 8'hA0;
    n_fac[9:5] = 5'h10;
    v_fac[9:5] = 5'h10;
    cyc(4);
    chk({factor_ok, loop_locked}, 8'hEC);
    cyc(LOCK_CYC + 12);
    chk(loop_locked, 4'hE);
    // serial use is legal on the first two slots only
    serial_mode = 4'h3;
    cyc(3);
    chk(loop_locked, 4'hE);
    serial_mode = 4'h8;
    cyc(3);
    chk(loop_locked, 4'h6);
  endtask
  // quarter steps of period 100, then delay both ways with clamping
  task automatic t_phase;
    for (int q = 0; q < 4; q++) begin
      phase_sel[1:0] = 2'(q);
      cyc(4);
      chk(phase_offset[10:0], 44'(q * 100 / 4));
    end
    delay_req[8:0] = 9'h1F6;
    cyc(4);
    chk(phase_offset[10:0], 44'h041);
    delay_req[8:0] = 9'h0C8;
    cyc(4);
    chk(phase_offset[10:0], 44'h0AF);
    delay_req[8:0] = 9'h138;
    cyc(4);
    chk(phase_offset[10:0], 44'h7E7);
  endtask
  // reference stops: lock holds inside the loss window, then drops
  task automatic t_loss;
    run = 1'b0;
    cyc(50);
    chk(loop_locked, 4'h6);
    cyc(30);
    chk(loop_locked, 4'h0);
  endtask
  // =====
  // main sequence
  initial begin
    cyc(2);
    sys_rst = 1'b0;
    chk({legacy_pair_ok, legacy_locked, loop_locked, lock_pin_oe}, 10'h000);
    cyc(1);
    chk({legacy_pair_ok, legacy_locked, loop_locked, lock_pin_oe}, 10'h20D);
    t_pairs();
    t_phase();
    t_legacy();
    t_lock();
    t_reprog();
    t_loss();
    wrap_up();
  end
  // watchdog: the sequence needs about 1400 cycles, allow 4000
  initial begin
    #100us;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
